// *** hw/ipend_defines.svh ***
// address map, field masks and reset values of the set-pending register block
//
// Notes on behaviour
// [RULE1] writing one to set word marks source pending
// [RULE2] written zero bits leave pending state unchanged
// [RULE3] reading returns one per pending source
// [RULE4] low word: port0 0-11, port1 0-11, port2 0-7
// [RULE5] high bits 0-7: port2 pins 8-11, port3 0-3
// [RULE6] high bits 8-19: the peripheral sources in order
// [RULE7] high bits 21-24: gpio ports 3 down to 0
// [RULE8] high bit 25: second sync serial port
// [RULE9] software writes zeros to reserved high bits
// [RULE10] reserved high bits read undefined, not relied on
// [RULE11] set words never remove a pending state
// [RULE12] clear word one clears pending, zero no effect
// [RULE13] one shared pending flag per source
`ifndef IPEND_DEFINES_SVH
`define IPEND_DEFINES_SVH

`define IPEND_SET_LOW_ADDR   32'hE000_E200
`define IPEND_SET_HIGH_ADDR  32'hE000_E204
`define IPEND_CLR_LOW_ADDR   32'hE000_E280
`define IPEND_CLR_HIGH_ADDR  32'hE000_E284
`define IPEND_STAT_ADDR      32'hE000_E2C0
`define IPEND_STAT_CLR_ADDR  32'hE000_E2C4
`define IPEND_IRQ_EN_ADDR    32'hE000_E2C8

`define IPEND_HIGH_MASK      32'h03EF_FFFF
`define IPEND_HIGH_PERIPH    32'h000F_FF00
`define IPEND_HIGH_GPIO      32'h01E0_0000
`define IPEND_HIGH_SERIAL1   32'h0200_0000

`define IPEND_EV_HW_NEW      0
`define IPEND_EV_RESV_WR     1
`define IPEND_EV_BAD_ADDR    2
`define IPEND_EV_W           3

`define IPEND_PEND_RST       32'h0000_0000
`define IPEND_EV_RST         3'h0
`define IPEND_WORD_ZERO      32'h0000_0000

`endif

// *** hw/ipend_pkg.sv ***
// types shared by the set-pending register block
package ipend_pkg;

    typedef enum logic [2:0] {
        IPEND_REG_NONE     = 3'b000,
        IPEND_REG_SET_LO   = 3'b001,
        IPEND_REG_SET_HI   = 3'b010,
        IPEND_REG_CLR_LO   = 3'b011,
        IPEND_REG_CLR_HI   = 3'b100,
        IPEND_REG_STAT     = 3'b101,
        IPEND_REG_STAT_CLR = 3'b110,
        IPEND_REG_IRQ_EN   = 3'b111
    } ipend_reg_t;

    typedef struct packed {
        logic [31:0] pend_low;
        logic [31:0] pend_high;
        logic [2:0]  stat;
        logic [2:0]  irq_en;
        logic [31:0] rdata;
        logic        slverr;
    } ipend_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } ipend_apb_req_t;

endpackage

// *** hw/ipend_sync.sv ***
// two-stage synchroniser for asynchronous request lines
`timescale 1ns/1ns
module ipend_sync #(
    parameter int WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } ipend_sync_t;

    ipend_sync_t st;
    ipend_sync_t next_st;

    // meta feeds only held; nothing else may look at it
    always_comb begin
        next_st      = st;
        next_st.meta = async_in;
        next_st.held = st.meta;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.held;

endmodule

// *** hw/ipend_regs.sv ***
// set-pending and clear-pending words with apb slave and event interrupt
`timescale 1ns/1ns
`include "ipend_defines.svh"
module ipend_regs #(
    parameter int LOW_SRCS  = 32,
    parameter int HIGH_SRCS = 32
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [LOW_SRCS-1:0]  src_req_low,
    input  wire logic [HIGH_SRCS-1:0] src_req_high,
    output logic      [31:0]          pending_low,
    output logic      [31:0]          pending_high,
    output logic                      irq
);

    ipend_pkg::ipend_state_t   st;
    ipend_pkg::ipend_state_t   next_st;
    ipend_pkg::ipend_apb_req_t req;
    ipend_pkg::ipend_reg_t     sel;

    logic [LOW_SRCS-1:0]  req_low_sync;
    logic [HIGH_SRCS-1:0] req_high_sync;
    logic [31:0]          hw_low;
    logic [31:0]          hw_high;
    logic                 setup;
    logic                 access;
    logic                 wr;
    logic [31:0]          set_low;
    logic [31:0]          set_high;
    logic [31:0]          clr_low;
    logic [31:0]          clr_high;
    logic [2:0]           stat_clr;
    logic [2:0]           events;
    logic [31:0]          rd_mux;

    // request lines come from pins and other blocks' domains
    ipend_sync #(
        .WIDTH (LOW_SRCS)
    ) u_sync_low (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (src_req_low),
        .sync_out (req_low_sync)
    );

    ipend_sync #(
        .WIDTH (HIGH_SRCS)
    ) u_sync_high (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (src_req_high),
        .sync_out (req_high_sync)
    );

    // widen to a full word; positions beyond the port width stay idle
    always_comb begin
        hw_low  = `IPEND_WORD_ZERO;
        hw_high = `IPEND_WORD_ZERO;
        hw_low[LOW_SRCS-1:0]   = req_low_sync;    // see [RULE4]
        hw_high[HIGH_SRCS-1:0] = req_high_sync;   // see [RULE5]
        hw_high = hw_high & `IPEND_HIGH_MASK;   // see [RULE6], [RULE7], [RULE8]
    end

    always_comb begin
        req.psel    = psel;
        req.penable = penable;
        req.pwrite  = pwrite;
        req.paddr   = paddr;
        req.pwdata  = pwdata;
    end

    always_comb begin
        unique case (req.paddr)
            `IPEND_SET_LOW_ADDR:  sel = ipend_pkg::IPEND_REG_SET_LO;
            `IPEND_SET_HIGH_ADDR: sel = ipend_pkg::IPEND_REG_SET_HI;
            `IPEND_CLR_LOW_ADDR:  sel = ipend_pkg::IPEND_REG_CLR_LO;
            `IPEND_CLR_HIGH_ADDR: sel = ipend_pkg::IPEND_REG_CLR_HI;
            `IPEND_STAT_ADDR:     sel = ipend_pkg::IPEND_REG_STAT;
            `IPEND_STAT_CLR_ADDR: sel = ipend_pkg::IPEND_REG_STAT_CLR;
            `IPEND_IRQ_EN_ADDR:   sel = ipend_pkg::IPEND_REG_IRQ_EN;
            default:              sel = ipend_pkg::IPEND_REG_NONE;
        endcase
    end

    assign setup  = req.psel & ~req.penable;
    assign access = req.psel & req.penable;
    assign wr     = access & req.pwrite;

    // write strobes; a write lands only at the access edge
    always_comb begin
        set_low  = `IPEND_WORD_ZERO;
        set_high = `IPEND_WORD_ZERO;
        clr_low  = `IPEND_WORD_ZERO;
        clr_high = `IPEND_WORD_ZERO;
        stat_clr = `IPEND_EV_RST;
        if (wr) begin
            unique case (sel)
                ipend_pkg::IPEND_REG_SET_LO:   set_low  = req.pwdata;   // see [RULE1]
                ipend_pkg::IPEND_REG_SET_HI:   set_high = req.pwdata;   // see [RULE1]
                ipend_pkg::IPEND_REG_CLR_LO:   clr_low  = req.pwdata;   // see [RULE12]
                ipend_pkg::IPEND_REG_CLR_HI:   clr_high = req.pwdata;   // see [RULE12]
                ipend_pkg::IPEND_REG_STAT_CLR: stat_clr = req.pwdata[`IPEND_EV_W-1:0];
                ipend_pkg::IPEND_REG_NONE,
                ipend_pkg::IPEND_REG_STAT,
                ipend_pkg::IPEND_REG_IRQ_EN: begin
                end
            endcase
        end
        // reserved positions are never stored, whatever software writes
        set_high = set_high & `IPEND_HIGH_MASK;   // see [RULE9]
        clr_high = clr_high & `IPEND_HIGH_MASK;
    end

    // events that software may watch through the status word
    always_comb begin
        events = `IPEND_EV_RST;
        events[`IPEND_EV_HW_NEW] = |(hw_low & ~st.pend_low) | |(hw_high & ~st.pend_high);
        events[`IPEND_EV_RESV_WR] = wr
            & ((sel == ipend_pkg::IPEND_REG_SET_HI) | (sel == ipend_pkg::IPEND_REG_CLR_HI))
            & |(req.pwdata & ~`IPEND_HIGH_MASK);
        events[`IPEND_EV_BAD_ADDR] = access & (sel == ipend_pkg::IPEND_REG_NONE);
    end

    // set and clear words alias the same flags
    always_comb begin
        rd_mux = `IPEND_WORD_ZERO;
        unique case (sel)
            ipend_pkg::IPEND_REG_SET_LO,
            ipend_pkg::IPEND_REG_CLR_LO: rd_mux = st.pend_low;    // see [RULE3]
            ipend_pkg::IPEND_REG_SET_HI,
            ipend_pkg::IPEND_REG_CLR_HI: rd_mux = st.pend_high;   // see [RULE13]
            ipend_pkg::IPEND_REG_STAT:   rd_mux[`IPEND_EV_W-1:0] = st.stat;
            ipend_pkg::IPEND_REG_IRQ_EN: rd_mux[`IPEND_EV_W-1:0] = st.irq_en;
            ipend_pkg::IPEND_REG_NONE,
            ipend_pkg::IPEND_REG_STAT_CLR: begin
            end
        endcase
    end

    always_comb begin
        next_st = st;
        // set-type terms are ored after the clear, so a request or set
        // in the same cycle as a clear leaves the source pending
        next_st.pend_low  = (st.pend_low & ~clr_low) | set_low | hw_low;      // see [RULE11]
        next_st.pend_high = (st.pend_high & ~clr_high) | set_high | hw_high;  // see [RULE2]
        next_st.stat      = (st.stat & ~stat_clr) | events;
        if (wr && sel == ipend_pkg::IPEND_REG_IRQ_EN) begin
            next_st.irq_en = req.pwdata[`IPEND_EV_W-1:0];
        end
        // read data is caught in the setup cycle and held through access
        if (setup) begin
            next_st.rdata  = rd_mux;                          // see [RULE10]
            next_st.slverr = (sel == ipend_pkg::IPEND_REG_NONE);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st.pend_low  <= `IPEND_PEND_RST;
            st.pend_high <= `IPEND_PEND_RST;
            st.stat      <= `IPEND_EV_RST;
            st.irq_en    <= `IPEND_EV_RST;
            st.rdata     <= `IPEND_WORD_ZERO;
            st.slverr    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // zero wait states: every access phase completes at once
    assign pready       = access;
    assign pslverr      = access & st.slverr;
    assign prdata       = st.rdata;
    assign pending_low  = st.pend_low;                        // see [RULE13]
    assign pending_high = st.pend_high;
    assign irq          = |(st.stat & st.irq_en);

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!rst_n);

    a_set_low_marks: assert property (   // see [RULE1]
        wr && sel == ipend_pkg::IPEND_REG_SET_LO
        |=> (pending_low & $past(pwdata)) == $past(pwdata)
    ) else $error("set write to low word did not mark sources pending");

    a_zero_bits_keep: assert property (   // see [RULE2]
        wr && sel == ipend_pkg::IPEND_REG_SET_HI
        |=> ((pending_high ^ $past(pending_high)) & ~$past(pwdata) & ~$past(hw_high))
            == `IPEND_WORD_ZERO
    ) else $error("zero bit of set write changed a pending flag");

    a_read_returns_pend: assert property (   // see [RULE3]
        setup && !pwrite && sel == ipend_pkg::IPEND_REG_SET_LO
        ##1 access
        |-> prdata == $past(pending_low)
    ) else $error("read of low set word did not return pending state");

    a_hw_low_pends: assert property (   // see [RULE4]
        hw_low != `IPEND_WORD_ZERO
        |=> (pending_low & $past(hw_low)) == $past(hw_low)
    ) else $error("low word request bit did not become pending");

    a_high_pin_map: assert property (   // see [RULE5]
        setup && !pwrite && sel == ipend_pkg::IPEND_REG_SET_HI
        ##1 access
        |-> prdata[7:0] == $past(pending_high[7:0])
    ) else $error("high word pin bits read back wrong");

    a_periph_bits_set: assert property (   // see [RULE6]
        wr && sel == ipend_pkg::IPEND_REG_SET_HI && (pwdata & `IPEND_HIGH_PERIPH) != 0
        |=> (pending_high & $past(pwdata) & `IPEND_HIGH_PERIPH)
            == ($past(pwdata) & `IPEND_HIGH_PERIPH)
    ) else $error("peripheral bits of high set word not marked");

    a_gpio_bits_set: assert property (   // see [RULE7]
        wr && sel == ipend_pkg::IPEND_REG_SET_HI
        |=> (pending_high & $past(pwdata) & `IPEND_HIGH_GPIO)
            == ($past(pwdata) & `IPEND_HIGH_GPIO)
    ) else $error("gpio port bits of high set word not marked");

    a_serial1_bit: assert property (   // see [RULE8]
        wr && sel == ipend_pkg::IPEND_REG_SET_HI && pwdata[25]
        |=> pending_high[25] [*2]
        or (wr && sel == ipend_pkg::IPEND_REG_CLR_HI)
    ) else $error("second serial port pending did not set");

    a_resv_never_set: assert property (   // see [RULE9]
        (pending_high & ~`IPEND_HIGH_MASK) == `IPEND_WORD_ZERO
    ) else $error("reserved high bit became pending");

    a_set_never_clears: assert property (   // see [RULE11]
        wr && (sel == ipend_pkg::IPEND_REG_SET_LO || sel == ipend_pkg::IPEND_REG_SET_HI)
        |=> ((pending_low & $past(pending_low)) == $past(pending_low))
            && ((pending_high & $past(pending_high)) == $past(pending_high))
    ) else $error("set write removed a pending state");

    a_clear_removes: assert property (   // see [RULE12]
        wr && sel == ipend_pkg::IPEND_REG_CLR_LO
        |=> (pending_low & $past(pwdata) & ~$past(hw_low)) == `IPEND_WORD_ZERO
    ) else $error("clear write left an idle source pending");

    a_shared_flag: assert property (   // see [RULE13]
        wr && sel == ipend_pkg::IPEND_REG_SET_LO
        ##1 setup && !pwrite && sel == ipend_pkg::IPEND_REG_CLR_LO
        ##1 access
        |-> (prdata & $past(pwdata, 2)) == $past(pwdata, 2)
    ) else $error("clear word read did not show a fresh set");

    a_irq_follows: assert property (
        wr && sel == ipend_pkg::IPEND_REG_STAT_CLR && pwdata[2:0] == 3'h7
        && events == `IPEND_EV_RST
        |=> !irq
    ) else $error("interrupt stayed high after all status cleared");

    // status flags, interrupt enable and the error response

    a_hw_new_flag: assert property (
        ((hw_low & ~pending_low) != `IPEND_WORD_ZERO)
        || ((hw_high & ~pending_high) != `IPEND_WORD_ZERO)
        |=> st.stat[`IPEND_EV_HW_NEW]
    ) else $error("new hardware request not flagged in status");

    a_resv_wr_flag: assert property (
        wr && (sel == ipend_pkg::IPEND_REG_SET_HI || sel == ipend_pkg::IPEND_REG_CLR_HI)
        && (pwdata & ~`IPEND_HIGH_MASK) != `IPEND_WORD_ZERO
        |=> st.stat[`IPEND_EV_RESV_WR]
    ) else $error("write of reserved ones not flagged in status");

    a_bad_addr_flag: assert property (
        access && sel == ipend_pkg::IPEND_REG_NONE
        |=> st.stat[`IPEND_EV_BAD_ADDR]
    ) else $error("unmapped access not flagged in status");

    a_bad_addr_err: assert property (
        access && sel == ipend_pkg::IPEND_REG_NONE
        |-> pslverr
    ) else $error("unmapped access completed without error");

    a_good_addr_ok: assert property (
        access && sel != ipend_pkg::IPEND_REG_NONE
        |-> !pslverr
    ) else $error("mapped access completed with error");

    a_stat_sticky: assert property (
        !(wr && sel == ipend_pkg::IPEND_REG_STAT_CLR)
        |=> (st.stat & $past(st.stat)) == $past(st.stat)
    ) else $error("status bit dropped without a clear write");

    a_stat_clr_write: assert property (
        wr && sel == ipend_pkg::IPEND_REG_STAT_CLR && events == `IPEND_EV_RST
        |=> (st.stat & $past(pwdata[`IPEND_EV_W-1:0])) == `IPEND_EV_RST
    ) else $error("status clear write left a bit set");

    a_irq_en_write: assert property (
        wr && sel == ipend_pkg::IPEND_REG_IRQ_EN
        |=> st.irq_en == $past(pwdata[`IPEND_EV_W-1:0])
    ) else $error("interrupt enable write not stored");

    // pending flags: second word, low word zero bits, clear words and read data

    a_set_high_marks: assert property (   // see [RULE1]
        wr && sel == ipend_pkg::IPEND_REG_SET_HI
        |=> (pending_high & $past(pwdata) & `IPEND_HIGH_MASK)
            == ($past(pwdata) & `IPEND_HIGH_MASK)
    ) else $error("set write to high word did not mark sources pending");

    a_low_zero_keep: assert property (   // see [RULE2]
        wr && sel == ipend_pkg::IPEND_REG_SET_LO
        |=> ((pending_low ^ $past(pending_low)) & ~$past(pwdata) & ~$past(hw_low))
            == `IPEND_WORD_ZERO
    ) else $error("zero bit of low set write changed a pending flag");

    a_hw_high_pends: assert property (   // see [RULE5]
        hw_high != `IPEND_WORD_ZERO
        |=> (pending_high & $past(hw_high)) == $past(hw_high)
    ) else $error("high word request bit did not become pending");

    a_clear_high_removes: assert property (   // see [RULE12]
        wr && sel == ipend_pkg::IPEND_REG_CLR_HI
        |=> (pending_high & $past(pwdata) & ~$past(hw_high)) == `IPEND_WORD_ZERO
    ) else $error("clear write left an idle high source pending");

    a_clear_zero_keeps: assert property (   // see [RULE12]
        wr && sel == ipend_pkg::IPEND_REG_CLR_LO
        |=> ($past(pending_low) & ~$past(pwdata) & ~pending_low) == `IPEND_WORD_ZERO
    ) else $error("zero bit of clear write removed a pending state");

    a_rdata_holds: assert property (   // see [RULE3]
        !setup
        |=> $stable(prdata)
    ) else $error("read data changed outside a setup edge");

endmodule

// *** bench/ipend_regs_tb.sv ***
// self-checking testbench of the set-pending register block
`timescale 1ns/1ns
`include "ipend_defines.svh"
module ipend_regs_tb;
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] src_req_low;
    logic [31:0] src_req_high;
    logic [31:0] pending_low;
    logic [31:0] pending_high;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [31:0] acc;
    int          fails;
    int          check_count;

    ipend_regs #(.LOW_SRCS(32), .HIGH_SRCS(32)) dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_req_low(src_req_low), .src_req_high(src_req_high),
        .pending_low(pending_low), .pending_high(pending_high), .irq(irq)
    );

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // zero wait states are expected and counted; only the watchdog ends a wait
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1);
        check("wait states", n, 32'h1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(negedge clock);
    endtask

    task automatic rd_chk(input string what, input logic [31:0] addr, input logic [31:0] mask,
                          input logic [31:0] exp);
        apb(1'h0, addr, 32'h0);
        check(what, rd & mask, exp);
    endtask

    task automatic t_reset();
        check("pending_low rst", pending_low, 32'h0);
        check("irq rst", {31'h0, irq}, 32'h0);
        rd_chk("set low rst", `IPEND_SET_LOW_ADDR, 32'hFFFF_FFFF, 32'h0);
        rd_chk("set high rst", `IPEND_SET_HIGH_ADDR, `IPEND_HIGH_MASK, 32'h0);
    endtask

    // port boundaries of the low word, accumulated one bit at a time
    task automatic t_set_low();
        int idx [6] = '{0, 11, 12, 23, 24, 31};
        acc = 32'h0;
        foreach (idx[i]) begin
            acc = acc | (32'h1 << idx[i]);
            apb(1'h1, `IPEND_SET_LOW_ADDR, 32'h1 << idx[i]);
            check("pending_low set", pending_low, acc);
        end
        rd_chk("set low read", `IPEND_SET_LOW_ADDR, 32'hFFFF_FFFF, acc);
        apb(1'h1, `IPEND_SET_LOW_ADDR, 32'h0);
        check("set low zero", pending_low, acc);
        rd_chk("clr low read", `IPEND_CLR_LOW_ADDR, 32'hFFFF_FFFF, acc);
        apb(1'h1, `IPEND_CLR_LOW_ADDR, 32'h0000_1000);
        check("clr low one", pending_low, acc & ~32'h0000_1000);
        apb(1'h1, `IPEND_CLR_LOW_ADDR, 32'hFFFF_FFFF);
        rd_chk("clr low all", `IPEND_SET_LOW_ADDR, 32'hFFFF_FFFF, 32'h0);
    endtask

    // set write, then at once a read of the clear word with no idle cycle
    task automatic t_back_to_back();
        @(posedge clock);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= 1'h1;
        paddr   <= `IPEND_SET_LOW_ADDR;
        pwdata  <= 32'h0000_0081;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        penable <= 1'h0;
        pwrite  <= 1'h0;
        paddr   <= `IPEND_CLR_LOW_ADDR;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        rd      = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(negedge clock);
        check("b2b clr read", rd, 32'h0000_0081);
        apb(1'h1, `IPEND_CLR_LOW_ADDR, 32'h0000_0081);
        check("b2b cleared", pending_low, 32'h0);
    endtask

    task automatic t_set_high();
        int idx [10] = '{0, 3, 4, 7, 8, 19, 21, 24, 25, 13};
        acc = 32'h0;
        foreach (idx[i]) begin
            acc = acc | (32'h1 << idx[i]);
            apb(1'h1, `IPEND_SET_HIGH_ADDR, 32'h1 << idx[i]);
            check("set high", pending_high & `IPEND_HIGH_MASK, acc);
        end
        rd_chk("set high read", `IPEND_SET_HIGH_ADDR, `IPEND_HIGH_MASK, acc);
        check("gpio bits", pending_high & `IPEND_HIGH_GPIO, 32'h0120_0000);
        check("serial1 bit", pending_high & `IPEND_HIGH_SERIAL1, 32'h0200_0000);
        apb(1'h1, `IPEND_CLR_HIGH_ADDR, 32'h0000_0100);
        check("clr high", pending_high & `IPEND_HIGH_MASK, acc & ~32'h100);
        apb(1'h1, `IPEND_CLR_HIGH_ADDR, `IPEND_HIGH_MASK);
        check("clr high all", pending_high & `IPEND_HIGH_MASK, 32'h0);
    endtask

    // reserved ones are written on purpose to see them flagged and no mapped bit set
    task automatic t_reserved();
        apb(1'h1, `IPEND_STAT_CLR_ADDR, 32'h7);
        apb(1'h1, `IPEND_SET_HIGH_ADDR, 32'hFC10_0000);
        rd_chk("resv no set", `IPEND_SET_HIGH_ADDR, `IPEND_HIGH_MASK, 32'h0);
        rd_chk("resv status", `IPEND_STAT_ADDR, 32'h7, 32'h2);
        apb(1'h0, 32'hE000_E300, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        rd_chk("unmapped status", `IPEND_STAT_ADDR, 32'h7, 32'h6);
        apb(1'h1, `IPEND_STAT_CLR_ADDR, 32'h7);
    endtask

    task automatic t_hw_irq();
        int n;
        n = 0;
        apb(1'h1, `IPEND_IRQ_EN_ADDR, 32'h1);
        @(posedge clock);
        src_req_low  <= 32'h0000_0020;
        src_req_high <= 32'h0200_0000;
        while (pending_low !== 32'h20 && n < 10) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        check("hw low", pending_low, 32'h20);
        check("hw high", pending_high & `IPEND_HIGH_MASK, 32'h0200_0000);
        check("irq on", {31'h0, irq}, 32'h1);
        rd_chk("hw read", `IPEND_SET_LOW_ADDR, 32'hFFFF_FFFF, 32'h20);
        @(posedge clock);
        src_req_low  <= 32'h0;
        src_req_high <= 32'h0;
        repeat (4) @(negedge clock);
        apb(1'h1, `IPEND_CLR_LOW_ADDR, 32'h20);
        apb(1'h1, `IPEND_CLR_HIGH_ADDR, 32'h0200_0000);
        check("hw clr", pending_low | pending_high, 32'h0);
        apb(1'h1, `IPEND_IRQ_EN_ADDR, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'h1, `IPEND_IRQ_EN_ADDR, 32'h1);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        apb(1'h1, `IPEND_STAT_CLR_ADDR, 32'h1);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    initial begin
        fails        = 0;
        check_count  = 0;
        rst_n        = 1'h0;
        psel         = 1'h0;
        penable      = 1'h0;
        pwrite       = 1'h0;
        paddr        = 32'h0;
        pwdata       = 32'h0;
        src_req_low  = 32'h0;
        src_req_high = 32'h0;
        repeat (8) @(posedge clock);
        rst_n <= 1'h1;
        @(negedge clock);
        t_reset();
        t_set_low();
        t_back_to_back();
        t_set_high();
        t_reserved();
        t_hw_irq();
        end_of_test();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        fails++;
        $display("ERROR watchdog expected done seen hang");
        end_of_test();
    end
endmodule
